// >>> common/etsc_regs.svh
// Register offsets, field positions, reset values and codes of the event timestamp capture block
`ifndef ETSC_REGS_SVH
`define ETSC_REGS_SVH

// ***************************************
// Register byte offsets
// ***************************************
`define ETSC_OFS_UNIT_INDEX   12'h520
`define ETSC_OFS_CTRL         12'h550
`define ETSC_OFS_S1_NSEC      12'h554
`define ETSC_OFS_S1_SEC       12'h558
`define ETSC_OFS_S1_PHASE     12'h55C
`define ETSC_OFS_S2_NSEC      12'h560
`define ETSC_OFS_S2_SEC       12'h564
`define ETSC_OFS_S2_PHASE     12'h568

// ***************************************
// Field positions
// ***************************************
`define ETSC_IDX_UNIT_BIT     8
`define ETSC_CTRL_RISE_BIT    7
`define ETSC_CTRL_FALL_BIT    6
`define ETSC_CTRL_OVF_BIT     16
`define ETSC_CTRL_CNT_LSB     17
`define ETSC_NSEC_POL_BIT     30

// ***************************************
// Sizes, reset values, limits
// ***************************************
`define ETSC_ADDR_W           12
`define ETSC_UNITS            2
`define ETSC_CNT_MAX          4'hF
`define ETSC_REG_RESET        32'h0000_0000

// ***************************************
// Phase codes per 8 ns slot of the 40 ns period
// ***************************************
`define ETSC_PH_0NS           3'h0
`define ETSC_PH_8NS           3'h1
`define ETSC_PH_16NS          3'h2
`define ETSC_PH_24NS          3'h3
`define ETSC_PH_32NS          3'h4
`define ETSC_SYS_PERIOD_NS    40
`define ETSC_SLOT_NS          8

`endif

// >>> common/etsc_pkg.sv
// Types shared by the event timestamp capture block
package etsc_pkg;

  typedef struct packed {
    logic        polarity;
    logic [29:0] nanosec;
    logic [31:0] sec;
    logic [2:0]  phase;
  } etsc_sample_t;

  typedef logic [2:0] etsc_slot_idx_t;

endpackage : etsc_pkg

// >>> common/etsc_cap_if.sv
// Link between the register bank and one capture unit
`timescale 1ns/100ps
interface etsc_cap_if;
  import etsc_pkg::*;

  logic         rise_capture_enable;
  logic         fall_capture_enable;
  logic         clear;
  logic [3:0]   event_count;
  logic         count_overflow;
  etsc_sample_t first_sample;
  etsc_sample_t second_sample;

  modport bank (
    output rise_capture_enable,
    output fall_capture_enable,
    output clear,
    input  event_count,
    input  count_overflow,
    input  first_sample,
    input  second_sample
  );

  modport unit (
    input  rise_capture_enable,
    input  fall_capture_enable,
    input  clear,
    output event_count,
    output count_overflow,
    output first_sample,
    output second_sample
  );
endinterface : etsc_cap_if

// >>> rtl/etsc_capture_unit.sv
// One timestamp input unit: edge detect and the first two capture slots
`timescale 1ns/100ps
`include "etsc_regs.svh"
module etsc_capture_unit (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  event_in,
  input  wire etsc_pkg::etsc_slot_idx_t event_slot,
  input  wire logic [31:0]           time_sec,
  input  wire logic [29:0]           time_nanosec,
  etsc_cap_if.unit                   cap
);
  import etsc_pkg::*;

  logic         prev_r,   prev_nxt;
  logic         armed_r,  armed_nxt;
  logic [3:0]   cnt_r,    cnt_nxt;
  logic         ovf_r,    ovf_nxt;
  etsc_sample_t s1_r,     s1_nxt;
  etsc_sample_t s2_r,     s2_nxt;
  logic         rise;
  logic         fall;
  logic         hit;
  logic [2:0]   phase_code;
  etsc_sample_t now;

  // ***************************************
  // Edge detection and phase coding
  // ***************************************
  always_comb
  begin
    // First cycle after reset only learns the input level, no false edge
    rise = armed_r & event_in & ~prev_r;
    fall = armed_r & ~event_in & prev_r;
    hit  = (rise & cap.rise_capture_enable) | (fall & cap.fall_capture_enable);
    unique case (event_slot)
      3'h0:    phase_code = `ETSC_PH_0NS;
      3'h1:    phase_code = `ETSC_PH_8NS;
      3'h2:    phase_code = `ETSC_PH_16NS;
      3'h3:    phase_code = `ETSC_PH_24NS;
      3'h4:    phase_code = `ETSC_PH_32NS;
      default: phase_code = `ETSC_PH_0NS;
    endcase
    now.polarity = rise;
    now.nanosec  = time_nanosec;
    now.sec      = time_sec;
    now.phase    = phase_code;
  end

  // ***************************************
  // Slot filling and event count
  // ***************************************
  always_comb
  begin
    prev_nxt  = event_in;
    armed_nxt = 1'b1;
    cnt_nxt   = cnt_r;
    ovf_nxt   = ovf_r;
    s1_nxt    = s1_r;
    s2_nxt    = s2_r;
    if (cap.clear)
    begin
      cnt_nxt = 4'h0;
      ovf_nxt = 1'b0;
      s1_nxt  = '0;
      s2_nxt  = '0;
    end
    // A capture in the clearing cycle counts as the first event
    if (hit)
    begin
      if (cap.clear || cnt_r == 4'h0)
        s1_nxt = now;
      else if (cnt_r == 4'h1)
        s2_nxt = now;
      if (cap.clear)
        cnt_nxt = 4'h1;
      else if (cnt_r == `ETSC_CNT_MAX)
        ovf_nxt = 1'b1;
      else
        cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
      cnt_r   <= 4'h0;
      ovf_r   <= 1'b0;
      s1_r    <= '0;
      s2_r    <= '0;
    end
    else
    begin
      prev_r  <= prev_nxt;
      armed_r <= armed_nxt;
      cnt_r   <= cnt_nxt;
      ovf_r   <= ovf_nxt;
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
    end
  end

  assign cap.event_count    = cnt_r;
  assign cap.count_overflow = ovf_r;
  assign cap.first_sample   = s1_r;
  assign cap.second_sample  = s2_r;

endmodule : etsc_capture_unit

// >>> rtl/etsc_top.sv
// Event timestamp capture block with its Avalon-MM register bank
//
// Contract
// - Sample registers exist once per unit and bit 8 of the unit index register picks the visible unit.
// - Bit 30 of a nanoseconds sample register is 1 for a rising edge and 0 for a falling edge.
// - Bits 29:0 of a nanoseconds sample hold the captured nanoseconds and bit 31 reads zero.
// - A seconds sample register holds the full 32-bit captured seconds.
// - Bits 2:0 of a phase register give the 8 ns slot of the 40 ns period and bits 31:3 read zero.
// - Phase codes are 000 for 0 ns, 001 for 8 ns, 010 for 16 ns, 011 for 24 ns and 100 for 32 ns; 101 to 111 are unused.
// - All sample registers are read-only and read zero after reset until a capture.
// - The first detected event fills the first slot and the second event fills the second slot.
// - Rising edges are captured only with enable bit 7 set and falling edges only with enable bit 6 set.
// - Edges are caught at up to one per 40 ns clock so pulse width follows from two timestamps.
`timescale 1ns/100ps
`include "etsc_regs.svh"
module etsc_top (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [`ETSC_ADDR_W-1:0]     avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic [`ETSC_UNITS-1:0]      event_in,
  input  wire etsc_pkg::etsc_slot_idx_t    event_slot [`ETSC_UNITS],
  input  wire logic [31:0]                 time_sec,
  input  wire logic [29:0]                 time_nanosec
);
  import etsc_pkg::*;

  logic                   ack_r,   ack_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic                   unit_r,  unit_nxt;
  logic [`ETSC_UNITS-1:0] rise_r,  rise_nxt;
  logic [`ETSC_UNITS-1:0] fall_r,  fall_nxt;
  logic [`ETSC_UNITS-1:0] clr_r,   clr_nxt;
  logic                   req;
  logic                   wr_go;
  logic [3:0]             cnt_v    [`ETSC_UNITS];
  logic                   ovf_v    [`ETSC_UNITS];
  etsc_sample_t           s1_v     [`ETSC_UNITS];
  etsc_sample_t           s2_v     [`ETSC_UNITS];
  etsc_sample_t           s1_sel;
  etsc_sample_t           s2_sel;

  etsc_cap_if cap_link [`ETSC_UNITS] ();

  // ***************************************
  // Capture units
  // ***************************************
  genvar gi;
  generate
    for (gi = 0; gi < `ETSC_UNITS; gi++)
    begin : g_unit
      assign cap_link[gi].rise_capture_enable = rise_r[gi];
      assign cap_link[gi].fall_capture_enable = fall_r[gi];
      assign cap_link[gi].clear               = clr_r[gi];
      assign cnt_v[gi]                        = cap_link[gi].event_count;
      assign ovf_v[gi]                        = cap_link[gi].count_overflow;
      assign s1_v[gi]                         = cap_link[gi].first_sample;
      assign s2_v[gi]                         = cap_link[gi].second_sample;

      etsc_capture_unit u_unit (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .event_in     (event_in[gi]),
        .event_slot   (event_slot[gi]),
        .time_sec     (time_sec),
        .time_nanosec (time_nanosec),
        .cap          (cap_link[gi])
      );
    end
  endgenerate

  // ***************************************
  // Bus handshake: one wait cycle per access
  // ***************************************
  always_comb
  begin
    req     = avs_read | avs_write;
    ack_nxt = req & ~ack_r;
    wr_go   = avs_write & ack_r;
  end

  assign avs_waitrequest = req & ~ack_r;

  // ***************************************
  // Register writes
  // ***************************************
  always_comb
  begin
    unit_nxt = unit_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    clr_nxt  = '0;
    if (wr_go)
    begin
      if (avs_address == `ETSC_OFS_UNIT_INDEX && avs_byteenable[1])
        unit_nxt = avs_writedata[`ETSC_IDX_UNIT_BIT];
      if (avs_address == `ETSC_OFS_CTRL && avs_byteenable[0])
      begin
        rise_nxt[unit_r] = avs_writedata[`ETSC_CTRL_RISE_BIT];
        fall_nxt[unit_r] = avs_writedata[`ETSC_CTRL_FALL_BIT];
        // Rewriting the enables rearms the unit for a fresh pair of samples
        clr_nxt[unit_r]  = 1'b1;
      end
    end
  end

  // ***************************************
  // Read data, chosen by the unit index
  // ***************************************
  always_comb
  begin
    s1_sel    = s1_v[unit_r];
    s2_sel    = s2_v[unit_r];
    rdata_nxt = rdata_r;
    if (ack_nxt)
    begin
      rdata_nxt = `ETSC_REG_RESET;
      if (avs_read)
      begin
        unique case (avs_address)
          `ETSC_OFS_UNIT_INDEX:
            rdata_nxt[`ETSC_IDX_UNIT_BIT] = unit_r;
          `ETSC_OFS_CTRL:
          begin
            rdata_nxt[`ETSC_CTRL_CNT_LSB +: 4] = cnt_v[unit_r];
            rdata_nxt[`ETSC_CTRL_OVF_BIT]      = ovf_v[unit_r];
            rdata_nxt[`ETSC_CTRL_RISE_BIT]     = rise_r[unit_r];
            rdata_nxt[`ETSC_CTRL_FALL_BIT]     = fall_r[unit_r];
          end
          `ETSC_OFS_S1_NSEC:
          begin
            rdata_nxt[`ETSC_NSEC_POL_BIT] = s1_sel.polarity;
            rdata_nxt[29:0]               = s1_sel.nanosec;
          end
          `ETSC_OFS_S1_SEC:
            rdata_nxt = s1_sel.sec;
          `ETSC_OFS_S1_PHASE:
            rdata_nxt[2:0] = s1_sel.phase;
          `ETSC_OFS_S2_NSEC:
          begin
            rdata_nxt[`ETSC_NSEC_POL_BIT] = s2_sel.polarity;
            rdata_nxt[29:0]               = s2_sel.nanosec;
          end
          `ETSC_OFS_S2_SEC:
            rdata_nxt = s2_sel.sec;
          `ETSC_OFS_S2_PHASE:
            rdata_nxt[2:0] = s2_sel.phase;
          default:
            rdata_nxt = `ETSC_REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r   <= 1'b0;
      rdata_r <= `ETSC_REG_RESET;
      unit_r  <= 1'b0;
      rise_r  <= '0;
      fall_r  <= '0;
      clr_r   <= '0;
    end
    else
    begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
      unit_r  <= unit_nxt;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
      clr_r   <= clr_nxt;
    end
  end

  // Sample registers have no write path at all
  assign avs_readdata = rdata_r;

endmodule : etsc_top

// >>> testbench/etsc_checker.sv
// Checker of the register bus and the sample register fields
`timescale 1ns/100ps
`include "etsc_regs.svh"
module etsc_checker (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic [`ETSC_ADDR_W-1:0]  avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_writedata,
  input wire logic [3:0]               avs_byteenable,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire logic [`ETSC_UNITS-1:0]   event_in,
  input wire etsc_pkg::etsc_slot_idx_t event_slot [`ETSC_UNITS],
  input wire logic [31:0]              time_sec,
  input wire logic [29:0]              time_nanosec
);
  import etsc_pkg::*;
  // ***************************************
  // Helpers
  // ***************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic done;
  logic hit;
  logic is_ns;
  logic is_ph;
  assign req   = avs_read | avs_write;
  assign done  = avs_read & ~avs_waitrequest;
  assign is_ns = avs_address == `ETSC_OFS_S1_NSEC || avs_address == `ETSC_OFS_S2_NSEC;
  assign is_ph = avs_address == `ETSC_OFS_S1_PHASE || avs_address == `ETSC_OFS_S2_PHASE;
  assign hit   = avs_address == `ETSC_OFS_UNIT_INDEX || avs_address == `ETSC_OFS_CTRL
              || (avs_address >= `ETSC_OFS_S1_NSEC && avs_address <= `ETSC_OFS_S2_PHASE
                  && avs_address[1:0] == 2'h0);
  // ***************************************
  // Assertions
  // ***************************************
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_rdata_hold: assert property (!$past(req && avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data changed without a request");
  a_nsec_rsvd: assert property (done && is_ns |-> !avs_readdata[31])
    else $error("nanoseconds reserved bit set");
  a_phase_code: assert property (done && is_ph |-> avs_readdata[31:3] == 29'h0 && avs_readdata[2:0] <= 3'h4)
    else $error("phase register out of range");
  a_unmapped_zero: assert property (done && !hit |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_count_full: assert property (done && avs_address == `ETSC_OFS_CTRL && avs_readdata[16]
    |-> avs_readdata[20:17] == 4'hF) else $error("overflow without full count");
  c_phase_read: cover property (done && is_ph);
  c_rise: cover property ($rose(event_in[0]));
  c_ctrl_write: cover property (avs_write && !avs_waitrequest && avs_address == `ETSC_OFS_CTRL);
endmodule : etsc_checker

bind etsc_top etsc_checker etsc_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_in(event_in),
  .event_slot(event_slot), .time_sec(time_sec), .time_nanosec(time_nanosec)
);

// >>> testbench/etsc_top_tb.sv
// Self-checking bench of the event timestamp capture block
`timescale 1ns/100ps
`include "etsc_regs.svh"
module etsc_top_tb;
  import etsc_pkg::*;
  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [11:0]    avs_address = 12'h0;
  logic           avs_read = 1'b0;
  logic           avs_write = 1'b0;
  logic [31:0]    avs_writedata = 32'h0;
  logic [3:0]     avs_byteenable = 4'h0;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  logic [1:0]     event_in = 2'h0;
  etsc_slot_idx_t event_slot [`ETSC_UNITS] = '{3'h0, 3'h0};
  logic [31:0]    time_sec = 32'h0;
  logic [29:0]    time_nanosec = 30'h0;
  logic [31:0]    exp_q [$];
  logic [31:0]    exp_d;
  logic [15:0]    lf = 16'h88D7;
  logic [31:0]    sv_ns [2];
  logic [31:0]    sv_s [2];
  logic [31:0]    sv_ph [2];
  int             bad_count = 0;
  int             num_checks = 0;
  int             cyc = 0;
  localparam logic [2:0] PH_TAB [8] = '{`ETSC_PH_0NS, `ETSC_PH_8NS, `ETSC_PH_16NS, `ETSC_PH_24NS,
                                        `ETSC_PH_32NS, 3'h0, 3'h0, 3'h0};
  always #20 sys_clk = ~sys_clk;
  etsc_top etsc_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_in(event_in),
    .event_slot(event_slot), .time_sec(time_sec), .time_nanosec(time_nanosec)
  );
  // ***************************************
  // Verdict, timeout and read monitor
  // ***************************************
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
    if (avs_read && !avs_waitrequest)
    begin
      exp_d = exp_q.pop_front();
      num_checks++;
      if (avs_readdata !== exp_d)
      begin
        bad_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, avs_readdata, exp_d);
      end
    end
  end
  // ***************************************
  // Bus and event drivers
  // ***************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Request held until the rising edge that sees waitrequest low; only the global timeout ends a hang
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest)
      @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask : wr
  // Drives one edge with fresh time; k names the slot it should fill, -1 for none
  task automatic hit(input int u, input logic v, input logic [2:0] s, input int k);
    lf = lfsr_next(lf);
    @(posedge sys_clk);
    event_in[u] <= v;
    event_slot[u] <= s;
    time_sec <= {lf, ~lf};
    time_nanosec <= {lf[13:0], lf};
    if (k >= 0)
    begin
      sv_ns[k] = {1'b0, v, lf[13:0], lf};
      sv_s[k] = {lf, ~lf};
      sv_ph[k] = {29'h0, PH_TAB[s]};
    end
  endtask : hit
  task automatic chk(input int k);
    rd(`ETSC_OFS_S1_NSEC + 12'(12 * k), sv_ns[k]);
    rd(`ETSC_OFS_S1_SEC + 12'(12 * k), sv_s[k]);
    rd(`ETSC_OFS_S1_PHASE + 12'(12 * k), sv_ph[k]);
  endtask : chk
  // ***************************************
  // Main sequence
  // ***************************************
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int u = 0; u < 2; u++)
    begin
      wr(`ETSC_OFS_UNIT_INDEX, 32'(u) << 8, 4'h2);
      for (int i = 0; i < 6; i++)
        rd(`ETSC_OFS_S1_NSEC + 12'(4 * i), 32'h0);
    end
    wr(`ETSC_OFS_S1_SEC, 32'hFFFF_FFFF, 4'hF);
    rd(`ETSC_OFS_S1_SEC, 32'h0);
    rd(12'h600, 32'h0);
    rd(`ETSC_OFS_UNIT_INDEX, 32'h100);
    wr(`ETSC_OFS_UNIT_INDEX, 32'h0, 4'h1);
    rd(`ETSC_OFS_UNIT_INDEX, 32'h100);
    for (int i = 0; i < 8; i++)
    begin
      wr(`ETSC_OFS_CTRL, 32'hC0, 4'h1);
      hit(1, ~event_in[1], 3'(i), 0);
      chk(0);
      rd(`ETSC_OFS_S2_NSEC, 32'h0);
    end
    wr(`ETSC_OFS_UNIT_INDEX, 32'h0, 4'h2);
    rd(`ETSC_OFS_S1_NSEC, 32'h0);
    wr(`ETSC_OFS_CTRL, 32'h80, 4'h1);
    hit(0, 1'b1, 3'h4, 0);
    hit(0, 1'b0, 3'h1, -1);
    hit(0, 1'b1, 3'h3, 1);
    hit(0, 1'b0, 3'h2, -1);
    chk(0);
    chk(1);
    rd(`ETSC_OFS_CTRL, 32'h0004_0080);
    wr(`ETSC_OFS_UNIT_INDEX, 32'h100, 4'h2);
    wr(`ETSC_OFS_CTRL, 32'h40, 4'h1);
    hit(1, 1'b1, 3'h1, -1);
    hit(1, 1'b0, 3'h0, 0);
    hit(1, 1'b1, 3'h3, -1);
    hit(1, 1'b0, 3'h2, 1);
    // Level comes from the loop index: event_in still holds last cycle's value when the next call starts
    for (int i = 0; i < 32; i++)
      hit(1, ~i[0], 3'h1, -1);
    chk(0);
    chk(1);
    rd(`ETSC_OFS_CTRL, 32'h001F_0040);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(`ETSC_OFS_UNIT_INDEX, 32'h100, 4'h2);
    rd(`ETSC_OFS_S2_SEC, 32'h0);
    @(posedge sys_clk);
    if (exp_q.size() != 0)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, exp_q.size(), 0);
    end
    report_and_stop();
  end
endmodule : etsc_top_tb
